// ==== control_method_consts.svh ====
// Constants for the control method selector: codes, fields, limits
`ifndef CONTROL_METHOD_CONSTS_SVH
`define CONTROL_METHOD_CONSTS_SVH

// Method and method-pair field codes
`define METHOD_SPEED          4'h0
`define METHOD_POSITION       4'h1
`define METHOD_FORCE          4'h2
`define METHOD_PRESET         4'h3
`define METHOD_PRESET_SPEED   4'h4
`define METHOD_PRESET_POS     4'h5
`define METHOD_PRESET_FORCE   4'h6
`define METHOD_POS_SPEED      4'h7
`define METHOD_POS_FORCE      4'h8
`define METHOD_FORCE_SPEED    4'h9
`define METHOD_SPEED_ZERO_CLAMP_INPUT   4'hA
`define METHOD_POS_INHIBIT    4'hB

// Allocation mode field values
`define ALLOC_FACTORY         4'h0
`define ALLOC_ALTERNATE       4'h1

// Input allocation setting: subfield positions and the unassigned code
`define ALLOC_DIR_LSB         0
`define ALLOC_SEL_A_LSB       4
`define ALLOC_SEL_B_LSB       8
`define ALLOC_CSEL_LSB        12
`define ALLOC_NONE            4'hF

// Contact vector bit positions
`define IN_DIR                0
`define IN_SEL_A              1
`define IN_SEL_B              2
`define IN_PMODE              3
`define IN_CSEL               4
`define IN_ZERO_CLAMP_INPUT             5
`define IN_INHIBIT            6
`define IN_COUNT              7

// Preset speed limit in 1 mm/s units, and reset values
`define PRESET_MAX            14'h2710
`define SPEED_RESET           14'h0000
`define INDEX_STOP            2'h0

`endif

// ==== control_method_pkg.sv ====
// Types shared by the control method selector
`default_nettype none
package control_method_pkg;

   typedef enum logic [2:0]
   {
      CTRL_INVALID,
      CTRL_PRESET,
      CTRL_SPEED,
      CTRL_POSITION,
      CTRL_FORCE,
      CTRL_SPEED_ZERO_CLAMP_INPUT,
      CTRL_POSITION_INHIBIT
   } control_mode_e;

   typedef enum logic
   {
      ST_LATCH,
      ST_RUN
   } startup_e;

   typedef struct packed
   {
      control_mode_e mode;
      logic          reverse;
      logic [1:0]    index;
   } decision_s;

endpackage : control_method_pkg
`default_nettype wire

// ==== contact_if.sv ====
// Raw and synchronised contact inputs between selector and synchroniser
`timescale 1ns/1ps
`default_nettype none
interface contact_if #(parameter int WIDTH = 7);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] synced;
   modport sync_side (input raw, output synced);
   modport user_side (output raw, input synced);
endinterface : contact_if
`default_nettype wire

// ==== contact_sync.sv ====
// Two-stage synchroniser for the contact inputs
`timescale 1ns/1ps
`default_nettype none
module contact_sync #(
   parameter int WIDTH = 7
) (
   input  wire logic         clock_i,
   input  wire logic         arst_n_i,
   contact_if.sync_side      contacts
);
   logic [WIDTH-1:0] stage_one;
   logic [WIDTH-1:0] stage_two;
   logic [WIDTH-1:0] next_stage_one;
   logic [WIDTH-1:0] next_stage_two;

   // Elaboration check: an empty contact vector has nothing to carry
   if (WIDTH < 1)
   begin : width_check
      $error("contact_sync needs at least one input");
   end

   always_comb
   begin
      next_stage_one = contacts.raw;
      next_stage_two = stage_one;
   end

   // Only the second stage is read, to keep metastability contained
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         stage_one <= '0;
         stage_two <= '0;
      end
      else
      begin
         stage_one <= next_stage_one;
         stage_two <= next_stage_two;
      end
   end

   assign contacts.synced = stage_two;
endmodule : contact_sync
`default_nettype wire

// ==== control_method_selector.sv ====
// Control method and preset speed selector for a drive
`timescale 1ns/1ps
`default_nettype none
`include "control_method_consts.svh"
module control_method_selector
   import control_method_pkg::*;
#(
   parameter int SPEED_W = 14
) (
   input  wire logic               clock_i,
   input  wire logic               arst_n_i,
   input  wire logic [3:0]         control_method_field_i,
   input  wire logic [3:0]         allocation_mode_field_i,
   input  wire logic [15:0]        input_allocation_setting_i,
   input  wire logic [SPEED_W-1:0] preset_speed_one_i,
   input  wire logic [SPEED_W-1:0] preset_speed_two_i,
   input  wire logic [SPEED_W-1:0] preset_speed_three_i,
   input  wire logic [SPEED_W-1:0] motor_max_speed_i,
   input  wire logic               direction_select_input_i,
   input  wire logic               speed_select_a_i,
   input  wire logic               speed_select_b_i,
   input  wire logic               proportional_mode_input_i,
   input  wire logic               control_select_input_i,
   input  wire logic               zero_clamp_input_i,
   input  wire logic               pulse_inhibit_input_i,
   output var  control_mode_e      active_mode_o,
   output logic                    reverse_o,
   output logic [1:0]              preset_index_o,
   output logic [SPEED_W-1:0]      speed_command_o,
   output logic                    config_ready_o
);
   if (SPEED_W != 14)
   begin : width_check
      $error("SPEED_W must be 14 to hold the preset range");
   end

   contact_if #(.WIDTH(`IN_COUNT)) contacts ();

   logic [`IN_COUNT-1:0] s;
   startup_e             state;
   startup_e             next_state;
   logic [3:0]           field;
   logic [3:0]           next_field;
   logic                 alt;
   logic                 next_alt;
   decision_s            dec;
   logic [SPEED_W-1:0]   next_speed;
   logic                 dir_eff;
   logic                 a_eff;
   logic                 b_eff;
   logic                 csel_eff;

   // Contacts are active high when closed
   assign contacts.raw = {pulse_inhibit_input_i, zero_clamp_input_i,
                          control_select_input_i, proportional_mode_input_i,
                          speed_select_b_i, speed_select_a_i,
                          direction_select_input_i};

   contact_sync #(.WIDTH(`IN_COUNT)) sync_u (
      .clock_i  (clock_i),
      .arst_n_i (arst_n_i),
      .contacts (contacts.sync_side)
   );

   assign s = contacts.synced;

   // Subfield check: an unassigned terminal never reads active
   function automatic logic assigned(input logic [15:0] setting,
                                     input int lsb);
      assigned = (setting[lsb +: 4] != `ALLOC_NONE);
   endfunction : assigned

   // Speed select pair to preset number, zero means stop
   function automatic logic [1:0] preset_of(input logic a, input logic b);
      logic [1:0] idx;
      idx = `INDEX_STOP;
      if (!a && b)
         idx = 2'h1;
      else if (a && b)
         idx = 2'h2;
      else if (a && !b)
         idx = 2'h3;
      preset_of = idx;
   endfunction : preset_of

   // Cap at the motor maximum and at the range limit
   function automatic logic [SPEED_W-1:0] cap(input logic [SPEED_W-1:0] v,
                                              input logic [SPEED_W-1:0] mx);
      logic [SPEED_W-1:0] lim;
      lim = (mx < `PRESET_MAX) ? mx : `PRESET_MAX;
      cap = (v > lim) ? lim : v;
   endfunction : cap

   always_comb
   begin
      if (alt)
      begin
         dir_eff  = s[`IN_DIR] &
                    assigned(input_allocation_setting_i, `ALLOC_DIR_LSB);
         a_eff    = s[`IN_SEL_A] &
                    assigned(input_allocation_setting_i, `ALLOC_SEL_A_LSB);
         b_eff    = s[`IN_SEL_B] &
                    assigned(input_allocation_setting_i, `ALLOC_SEL_B_LSB);
         csel_eff = s[`IN_CSEL] &
                    assigned(input_allocation_setting_i, `ALLOC_CSEL_LSB);
      end
      else
      begin
         // Factory pins: proportional mode doubles as direction
         dir_eff  = s[`IN_PMODE];
         a_eff    = s[`IN_SEL_A];
         b_eff    = s[`IN_SEL_B];
         csel_eff = 1'b0;
      end
   end

   // Method decode from latched field and synchronised contacts
   always_comb
   begin
      control_mode_e other;
      logic          sw;
      other = CTRL_SPEED;
      sw    = alt ? csel_eff : s[`IN_PMODE];
      dec.mode    = CTRL_INVALID;
      dec.reverse = 1'b0;
      dec.index   = `INDEX_STOP;
      case (field)
         `METHOD_SPEED:    dec.mode = CTRL_SPEED;
         `METHOD_POSITION: dec.mode = CTRL_POSITION;
         `METHOD_FORCE:    dec.mode = CTRL_FORCE;
         `METHOD_PRESET,
         `METHOD_PRESET_SPEED,
         `METHOD_PRESET_POS,
         `METHOD_PRESET_FORCE:
         begin
            if (field == `METHOD_PRESET_POS)
               other = CTRL_POSITION;
            else if (field == `METHOD_PRESET_FORCE)
               other = CTRL_FORCE;
            if (field != `METHOD_PRESET && alt && csel_eff)
               dec.mode = other;
            else if (field != `METHOD_PRESET && !alt && !a_eff && !b_eff)
               dec.mode = other;
            else
            begin
               dec.mode    = CTRL_PRESET;
               dec.reverse = dir_eff;
               dec.index   = preset_of(a_eff, b_eff);
            end
         end
         `METHOD_POS_SPEED:   dec.mode = sw ? CTRL_SPEED : CTRL_POSITION;
         `METHOD_POS_FORCE:   dec.mode = sw ? CTRL_FORCE : CTRL_POSITION;
         `METHOD_FORCE_SPEED: dec.mode = sw ? CTRL_SPEED : CTRL_FORCE;
         // zero clamp and pulse inhibit pairs
         `METHOD_SPEED_ZERO_CLAMP_INPUT:
            dec.mode = (alt ? s[`IN_ZERO_CLAMP_INPUT] : s[`IN_PMODE]) ?
                       CTRL_SPEED_ZERO_CLAMP_INPUT : CTRL_SPEED;
         `METHOD_POS_INHIBIT:
            dec.mode = (alt ? s[`IN_INHIBIT] : s[`IN_PMODE]) ?
                       CTRL_POSITION_INHIBIT : CTRL_POSITION;
         default: dec.mode = CTRL_INVALID;
      endcase
   end

   // preset value applied at once, capped
   always_comb
   begin
      case (dec.index)
         2'h1:    next_speed = cap(preset_speed_one_i, motor_max_speed_i);
         2'h2:    next_speed = cap(preset_speed_two_i, motor_max_speed_i);
         2'h3:    next_speed = cap(preset_speed_three_i, motor_max_speed_i);
         default: next_speed = `SPEED_RESET;
      endcase
   end

   always_comb
   begin
      next_state = state;
      next_field = field;
      next_alt   = alt;
      case (state)
         ST_LATCH:
         begin
            next_field = control_method_field_i;
            next_alt   = (allocation_mode_field_i == `ALLOC_ALTERNATE);
            next_state = ST_RUN;
         end
         ST_RUN:  next_state = ST_RUN;
         default: next_state = ST_LATCH;
      endcase
   end

   // Outputs follow the decode one cycle later, idle until latched
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         state           <= ST_LATCH;
         field           <= `METHOD_SPEED;
         alt             <= 1'b0;
         active_mode_o   <= CTRL_INVALID;
         reverse_o       <= 1'b0;
         preset_index_o  <= `INDEX_STOP;
         speed_command_o <= `SPEED_RESET;
         config_ready_o  <= 1'b0;
      end
      else
      begin
         state           <= next_state;
         field           <= next_field;
         alt             <= next_alt;
         active_mode_o   <= (state == ST_RUN) ? dec.mode : CTRL_INVALID;
         reverse_o       <= (state == ST_RUN) & dec.reverse;
         preset_index_o  <= (state == ST_RUN) ? dec.index : `INDEX_STOP;
         speed_command_o <= (state == ST_RUN) ? next_speed : `SPEED_RESET;
         config_ready_o  <= (state == ST_RUN);
      end
   end

   alt_select_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && alt && field == `METHOD_PRESET_FORCE)
      |=> active_mode_o == ($past(csel_eff) ? CTRL_FORCE : CTRL_PRESET))
      else $error("alternate selector decode wrong");
   preset_stop_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && dec.mode == CTRL_PRESET && !a_eff && !b_eff)
      |=> preset_index_o == 2'h0 && speed_command_o == `SPEED_RESET)
      else $error("preset stop not at speed zero");
   forward_preset_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && dec.mode == CTRL_PRESET && !dir_eff
       && a_eff && !b_eff)
      |=> !reverse_o && preset_index_o == 2'h3)
      else $error("forward preset three wrong");
   reverse_preset_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && dec.mode == CTRL_PRESET && dir_eff
       && !a_eff && b_eff)
      |=> reverse_o && preset_index_o == 2'h1)
      else $error("reverse preset one wrong");
   pair_switch_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && !alt && field == `METHOD_POS_FORCE)
      |=> active_mode_o == ($past(s[`IN_PMODE]) ? CTRL_FORCE
                                                 : CTRL_POSITION))
      else $error("position/force pair decode wrong");
   zero_clamp_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && !alt && field == `METHOD_SPEED_ZERO_CLAMP_INPUT
       && s[`IN_PMODE])
      |=> active_mode_o == CTRL_SPEED_ZERO_CLAMP_INPUT)
      else $error("zero clamp not selected");
   inhibit_ignored_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && alt && field == `METHOD_SPEED_ZERO_CLAMP_INPUT)
      |=> active_mode_o == ($past(s[`IN_ZERO_CLAMP_INPUT]) ? CTRL_SPEED_ZERO_CLAMP_INPUT
                                                  : CTRL_SPEED))
      else $error("zero clamp pair uses wrong input");
   unassigned_sel_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && alt && field == `METHOD_PRESET_SPEED
       && input_allocation_setting_i[15:12] == `ALLOC_NONE)
      |=> active_mode_o == CTRL_PRESET)
      else $error("unassigned selector acted");
   speed_cap_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      1'b1 |=> speed_command_o <= `PRESET_MAX
               && speed_command_o <= $past(motor_max_speed_i))
      else $error("preset speed exceeds limit");
   field_held_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN) |=> field == $past(field) && alt == $past(alt))
      else $error("method field changed without restart");
   sync_delay_a : assert property (
      @(posedge clock_i) disable iff (!arst_n_i)
      (state == ST_RUN && !alt && field == `METHOD_POS_SPEED)
      |-> ##3 active_mode_o == ($past(proportional_mode_input_i, 3)
                                 ? CTRL_SPEED : CTRL_POSITION))
      else $error("contact not seen after two sync stages");
endmodule : control_method_selector
`default_nettype wire

// ==== contact_host.sv ====
// Host side model driving the seven contact inputs
`timescale 1ns/1ps
`default_nettype none
module contact_host (
   input  wire logic       clock_i,
   input  wire logic       slow_i,
   input  wire logic [6:0] want_i,
   output logic      [6:0] contact_o
);
   logic [6:0] stage;

   initial
   begin
      stage = 7'h00;
      contact_o = 7'h00;
   end

   // closed contact is one
   // Slow mode lags one cycle, like a late relay
   always @(negedge clock_i)
   begin
      stage <= want_i;
      contact_o <= slow_i ? stage : want_i;
   end
endmodule : contact_host
`default_nettype wire

// ==== control_method_selector_tb_top.sv ====
// Self-checking bench for the control method selector
`timescale 1ns/1ps
`default_nettype none
`include "control_method_consts.svh"
module control_method_selector_tb_top
   import control_method_pkg::*;
;
   logic          clock_i = 1'b0;
   logic          arst_n = 1'b0;
   logic          slow = 1'b0;
   logic [3:0]    method = 4'h4;
   logic [3:0]    alloc = 4'h1;
   logic [15:0]   asg = 16'h3210;
   logic [13:0]   ps [1:3] = '{14'h0064, 14'h00C8, 14'h2EE0};
   logic [13:0]   mx = 14'h2328;
   logic [6:0]    want = 7'h00;
   logic [6:0]    pin;
   control_mode_e mode;
   logic          rev;
   logic [1:0]    idx;
   logic [13:0]   spd;
   logic          ready;
   int            error_cnt = 0;
   int            total_checks = 0;

   always #2.5 clock_i = ~clock_i;

   contact_host host (.clock_i(clock_i), .slow_i(slow), .want_i(want),
                      .contact_o(pin));

   control_method_selector #(.SPEED_W(14)) dut (
      .clock_i                   (clock_i),
      .arst_n_i                  (arst_n),
      .control_method_field_i    (method),
      .allocation_mode_field_i   (alloc),
      .input_allocation_setting_i(asg),
      .preset_speed_one_i        (ps[1]),
      .preset_speed_two_i        (ps[2]),
      .preset_speed_three_i      (ps[3]),
      .motor_max_speed_i         (mx),
      .direction_select_input_i  (pin[`IN_DIR]),
      .speed_select_a_i          (pin[`IN_SEL_A]),
      .speed_select_b_i          (pin[`IN_SEL_B]),
      .proportional_mode_input_i (pin[`IN_PMODE]),
      .control_select_input_i    (pin[`IN_CSEL]),
      .zero_clamp_input_i        (pin[`IN_ZERO_CLAMP_INPUT]),
      .pulse_inhibit_input_i     (pin[`IN_INHIBIT]),
      .active_mode_o             (mode),
      .reverse_o                 (rev),
      .preset_index_o            (idx),
      .speed_command_o           (spd),
      .config_ready_o            (ready)
   );

   task automatic check(input string what, input logic [15:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic give_verdict();
      if (error_cnt == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   // Expected speed: preset limited by motor max and the top of range
   function automatic logic [15:0] cap(input logic [13:0] p);
      logic [13:0] c;
      c = (p > mx) ? mx : p;
      if (c > `PRESET_MAX)
         c = `PRESET_MAX;
      return {2'h0, c};
   endfunction : cap

   // Reset with new configuration, fields set before release
   task automatic restart(input logic [3:0] m, al, input logic [15:0] s);
      @(negedge clock_i);
      arst_n <= 1'b0;
      method <= m;
      alloc <= al;
      asg <= s;
      want <= 7'h00;
      repeat (2) @(negedge clock_i);
      check("mode_in_reset", mode, CTRL_INVALID);
      check("ready_in_reset", ready, 16'h0000);
      arst_n <= 1'b1;
      repeat (8) @(posedge clock_i);
      #1;
      check("ready", ready, 16'h0001);
   endtask : restart

   // Contacts take three edges plus host lag, so six is safe
   task automatic apply(input logic [6:0] v);
      @(negedge clock_i);
      want <= v;
      repeat (6) @(posedge clock_i);
      #1;
   endtask : apply

   task automatic run_alt_preset();
      logic [6:0] v;
      logic [1:0] e;
      for (int m = 4; m <= 6; m++)
      begin
         slow <= (m == 5);
         restart(m[3:0], 4'h1, 16'h3210);
         for (int i = 0; i < 16; i++)
         begin
            v = 7'h00;
            v[`IN_DIR] = i[0];
            v[`IN_SEL_A] = i[1];
            v[`IN_SEL_B] = i[2];
            v[`IN_CSEL] = i[3];
            apply(v);
            e = i[1] ? (i[2] ? 2'h2 : 2'h3) : (i[2] ? 2'h1 : 2'h0);
            if (i[3])
            begin
               check("direct_mode", mode, m - 2);
               check("direct_idx", idx, 16'h0000);
               check("direct_rev", rev, 16'h0000);
               check("direct_spd", spd, 16'h0000);
            end
            else
            begin
               check("preset_mode", mode, CTRL_PRESET);
               check("preset_idx", idx, e);
               check("preset_spd", spd, e ? cap(ps[e]) : 16'h0000);
               if (e != 2'h0)
                  check("preset_rev", rev, i[0]);
            end
         end
      end
      slow <= 1'b0;
   endtask : run_alt_preset

   task automatic run_switch();
      logic [6:0]  v;
      logic        sw;
      logic [15:0] e;
      for (int al = 0; al < 2; al++)
         for (int m = 7; m <= 11; m++)
         begin
            restart(m[3:0], al[3:0], 16'h3210);
            for (int i = 0; i < 16; i++)
            begin
               v = 7'h00;
               v[`IN_PMODE] = i[0];
               v[`IN_CSEL] = i[1];
               v[`IN_ZERO_CLAMP_INPUT] = i[2];
               v[`IN_INHIBIT] = i[3];
               apply(v);
               sw = al ? i[1] : i[0];
               case (m)
                  7: e = sw ? CTRL_SPEED : CTRL_POSITION;
                  8: e = sw ? CTRL_FORCE : CTRL_POSITION;
                  9: e = sw ? CTRL_SPEED : CTRL_FORCE;
                  10: e = (al ? i[2] : i[0]) ? CTRL_SPEED_ZERO_CLAMP_INPUT : CTRL_SPEED;
                  default: e = (al ? i[3] : i[0]) ? CTRL_POSITION_INHIBIT
                                                  : CTRL_POSITION;
               endcase
               check("switch_mode", mode, e);
            end
         end
   endtask : run_switch

   // Preset speed limits act one cycle after a change
   task automatic run_cap();
      restart(4'h4, 4'h1, 16'h3210);
      apply(7'h02);
      check("cap_max", spd, cap(ps[3]));
      @(negedge clock_i);
      mx <= 14'h3FFF;
      repeat (2) @(posedge clock_i);
      #1;
      check("cap_range", spd, 16'h2710);
      @(negedge clock_i);
      mx <= 14'h0032;
      repeat (2) @(posedge clock_i);
      #1;
      check("cap_motor", spd, 16'h0032);
      // A new preset below both limits is used one cycle after the change
      @(negedge clock_i);
      mx <= 14'h2328;
      ps[3] <= 14'h1234;
      repeat (2) @(posedge clock_i);
      #1;
      check("new_preset", spd, 16'h1234);
      @(negedge clock_i);
      ps[3] <= 14'h2EE0;
   endtask : run_cap

   // Unassigned control select reads as open
   task automatic run_unassigned();
      restart(4'h4, 4'h1, 16'hF210);
      apply(7'h14);
      check("unassigned_mode", mode, CTRL_PRESET);
      check("unassigned_idx", idx, 16'h0001);
   endtask : run_unassigned

   // Field changes after startup are ignored
   task automatic run_latch();
      restart(4'h7, 4'h0, 16'h3210);
      @(negedge clock_i);
      method <= 4'h8;
      alloc <= 4'h1;
      apply(7'h08);
      check("latched_mode", mode, CTRL_SPEED);
   endtask : run_latch

   // Factory pins: proportional mode is the direction and both selects
   // off hand over to the paired method; field 3 stays on the presets
   task automatic run_factory();
      logic [6:0] v;
      logic [1:0] e;
      for (int m = 3; m <= 6; m++)
      begin
         restart(m[3:0], 4'h0, 16'h3210);
         for (int i = 0; i < 8; i++)
         begin
            v = 7'h00;
            v[`IN_PMODE] = i[0];
            v[`IN_SEL_A] = i[1];
            v[`IN_SEL_B] = i[2];
            apply(v);
            e = i[1] ? (i[2] ? 2'h2 : 2'h3) : (i[2] ? 2'h1 : 2'h0);
            if (e == 2'h0 && m != 3)
               check("fac_mode", mode, m - 2);
            else
            begin
               check("fac_mode", mode, CTRL_PRESET);
               check("fac_idx", idx, e);
               check("fac_spd", spd, e ? cap(ps[e]) : 16'h0000);
               if (e != 2'h0)
                  check("fac_rev", rev, i[0]);
            end
         end
      end
      // Single-method fields ignore the contacts, unused codes are invalid
      for (int m = 0; m < 4; m++)
      begin
         restart((m == 3) ? 4'hC : m[3:0], 4'h0, 16'h3210);
         apply(7'h7F);
         check("fixed_mode", mode, (m == 3) ? 0 : m + 2);
         check("fixed_idx", idx, 16'h0000);
      end
   endtask : run_factory

   initial
   begin
      repeat (2) @(negedge clock_i);
      arst_n <= 1'b1;
      run_alt_preset();
      run_factory();
      run_switch();
      run_cap();
      run_unassigned();
      run_latch();
      give_verdict();
   end

   // Watchdog at about five times the expected run of 2000 cycles
   initial
   begin
      #50000;
      error_cnt++;
      give_verdict();
   end
endmodule : control_method_selector_tb_top
`default_nettype wire
